// file: rtl/irt_pkg.sv
// Shared constants, types and decode helpers for the two-wire register access target.
// Assumes a byte-wide core register space behind a one-strobe-per-byte command port.
package irt_pkg;

  // Fixed 7-bit target address matched in the first byte after a START.
  localparam logic [6:0]   TARGET_ADDR = 7'h64;
  // Register pointer value after reset.
  localparam logic [7:0]   PTR_RESET   = 8'h00;
  // Bit counter value of the last bit of a byte.
  localparam logic [2:0]   BIT_LAST    = 3'h7;
  // Reset values of the link pin synchroniser: clock, data, core ready, enable.
  localparam logic [3:0]   PIN_INIT    = 4'hc;
  // One bit per register address that holds the low byte of a 16-bit field.
  localparam logic [255:0] WIDE_LO_MAP = 256'h0004_0000_0000_0000_0000_0000_0000_0000;

  // Link engine states.
  typedef enum logic [2:0] {
    ST_IDLE,   // Not addressed; waiting for a START.
    ST_ADDR,   // Shifting in the target address byte.
    ST_REG,    // Shifting in the register address byte.
    ST_WDATA,  // Shifting in write data bytes.
    ST_ACK,    // Driving our acknowledge on the ninth clock.
    ST_RDATA,  // Shifting out read data.
    ST_RACK    // Sampling the controller acknowledge.
  } irt_state_t;

  // Kind of the previous access, used for the 16-bit pairing.
  typedef enum logic [1:0] {
    LAST_NONE,
    LAST_RD_LO,
    LAST_WR_LO
  } irt_last_t;

  // Byte request handed from the link domain to the core domain.
  typedef struct packed {
    logic       wr;     // High for a write, low for a read.
    logic [7:0] addr;   // Register pointer at the time of the byte.
    logic [7:0] wdata;  // Write data byte.
  } irt_lreq_t;

  // Command strobe presented to the core register file.
  typedef struct packed {
    logic        rd;     // One-cycle read strobe.
    logic        wr;     // One-cycle write strobe.
    logic        pair;   // With wr: completes an ordered 16-bit write.
    logic [7:0]  addr;   // Byte address.
    logic [7:0]  wdata;  // Byte written.
    logic [15:0] wword;  // Whole 16-bit value when pair is high.
  } irt_cmd_t;

  // True when the address holds the low byte of a 16-bit field.
  function automatic logic irt_wide_lo(input logic [7:0] a);
    return WIDE_LO_MAP[a];
  endfunction

  // True when the address holds the high byte of a 16-bit field.
  function automatic logic irt_wide_hi(input logic [7:0] a);
    return WIDE_LO_MAP[a - 8'h01];
  endfunction

endpackage

// file: rtl/irt_sync.sv
// Two flip-flop synchroniser for levels and toggles of any width.
// Assumes each bit is independent or held stable while its partner bits settle.
module irt_sync #(
  parameter int         W    = 1,   // Number of bits.
  parameter logic [W-1:0] INIT = '0 // Value held during reset.
) (
  input  wire logic         clk,    // Destination clock.
  input  wire logic         rst_n,  // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,      // Asynchronous input.
  output logic      [W-1:0] q       // Synchronised output.
);

  logic [W-1:0] meta_reg;  // First stage, read only by the second stage.

  // The first stage may go metastable; only the second stage is exported.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      q        <= INIT;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// file: rtl/irt_xfer.sv
// Core-domain end of the byte handshake: strobes the register file once per byte.
// Assumes the link holds its request stable from its toggle until our answer toggle.
// Assumes core_rd_word is valid in the cycle after a read strobe.
module irt_xfer (
  input  wire logic             clk,         // Core clock.
  input  wire logic             rst_n,       // Asynchronous reset, active low.
  input  wire logic             ce,          // Clock enable; freezes state when low.
  input  wire logic             req_tgl,     // Request toggle from the link domain.
  input  wire irt_pkg::irt_lreq_t req,       // Request word, stable while pending.
  input  wire logic [15:0]      rd_word,     // Core read data, high byte above.
  output logic                  ack_tgl,     // Answer toggle to the link domain.
  output logic [7:0]            rsp_byte,    // Read answer, stable until next request.
  output irt_pkg::irt_cmd_t     cmd          // Register file command.
);

  logic               tgl_s;       // Synchronised request toggle.
  logic               seen_reg;    // Last request toggle served.
  logic               new_req;     // A new request has arrived.
  logic [1:0]         pipe_reg;    // Wait stages until read data are valid.
  logic               hi_rd_reg;   // This read is the high half of a latched pair.
  logic [7:0]         shadow_reg;  // Latched upper half of a 16-bit field.
  logic [7:0]         stage_reg;   // Staged low byte of a 16-bit write.
  logic [7:0]         last_addr;   // Address of the previous access.
  irt_pkg::irt_last_t last_kind;   // Kind of the previous access.
  logic               pair_ok;     // Request follows its partner byte directly.

  irt_sync #(.W(1), .INIT(1'b0)) u_req_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (req_tgl),
    .q     (tgl_s)
  );

  assign new_req = tgl_s != seen_reg;
  assign pair_ok = irt_pkg::irt_wide_hi(req.addr) && (last_addr == req.addr - 8'h01);

  // RULE19 byte strobes
  // One strobe per byte; strobes last a single cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd      <= '0;
      seen_reg <= 1'b0;
      pipe_reg <= 2'h0;
    end else if (ce) begin
      cmd.rd   <= 1'b0;
      cmd.wr   <= 1'b0;
      cmd.pair <= 1'b0;
      pipe_reg <= {pipe_reg[0], new_req};
      if (new_req) begin
        seen_reg  <= tgl_s;
        cmd.rd    <= ~req.wr;
        cmd.wr    <= req.wr;
        cmd.addr  <= req.addr;
        cmd.wdata <= req.wdata;
        // RULE9 ordered pair
        cmd.pair  <= req.wr && pair_ok && (last_kind == irt_pkg::LAST_WR_LO);
        cmd.wword <= {req.wdata, stage_reg};
      end
    end
  end

  // Remembers the previous access so that a high byte knows its partner came first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_kind <= irt_pkg::LAST_NONE;
      last_addr <= 8'h00;
      stage_reg <= 8'h00;
      hi_rd_reg <= 1'b0;
    end else if (ce && new_req) begin
      last_addr <= req.addr;
      hi_rd_reg <= ~req.wr && pair_ok && (last_kind == irt_pkg::LAST_RD_LO);
      if (!irt_pkg::irt_wide_lo(req.addr)) begin
        last_kind <= irt_pkg::LAST_NONE;
      end else if (req.wr) begin
        last_kind <= irt_pkg::LAST_WR_LO;
        stage_reg <= req.wdata;
      end else begin
        last_kind <= irt_pkg::LAST_RD_LO;
      end
    end
  end

  // RULE7 shadow latch
  // Reading a low byte freezes the upper half, so a high read that directly follows it is coherent.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reg <= 8'h00;
      rsp_byte   <= 8'h00;
      ack_tgl    <= 1'b0;
    end else if (ce && pipe_reg[1]) begin
      ack_tgl <= ~ack_tgl;
      if (cmd.wr) begin
        rsp_byte <= rsp_byte;
      end else if (irt_pkg::irt_wide_lo(cmd.addr)) begin
        shadow_reg <= rd_word[15:8];
        rsp_byte   <= rd_word[7:0];
      end else if (hi_rd_reg) begin
        rsp_byte <= shadow_reg;
      end else begin
        rsp_byte <= rd_word[7:0];
      end
    end
  end

endmodule

// file: rtl/irt_target.sv
// Two-wire serial target giving an external controller access to the byte registers.
// Assumes open-drain pins resolved outside, a free-running oversampling port clock,
// and a core register file on sys_clk that answers reads one cycle after the strobe.
//
// Functional notes
// RULE1 - Answer only our fixed 7-bit address.
// RULE2 - Work at standard and fast bus rates.
// RULE3 - Keep an 8-bit register pointer.
// RULE4 - Pointer increments after every data byte.
// RULE5 - Pointer survives STOP and bus release.
// RULE6 - Reads without address byte continue at pointer.
// RULE7 - Low-byte read latches whole 16-bit field.
// RULE8 - Controller reads high byte right after low.
// RULE9 - 16-bit write applies only on ordered pair.
// RULE10 - Write: start, address, register, data, stop.
// RULE11 - Drive acknowledge on ninth clock of bytes.
// RULE12 - Controller may stop after our not-acknowledge.
// RULE13 - Read: address, register, restart, address, data.
// RULE14 - Controller acknowledges all read bytes but last.
// RULE15 - Release data line on final not-acknowledge.
// RULE16 - Controller should prefer multi-byte bursts.
// RULE17 - Ignore bus while core still initialising.
// RULE18 - Wake core for transactions addressed to us.
// RULE19 - One register strobe per transferred byte.
module irt_target (
  input  wire logic              sys_clk,       // Core clock, 10 MHz.
  input  wire logic              rst_n,         // Asynchronous reset, active low.
  input  wire logic              ce,            // Clock enable; freezes state when low.
  input  wire logic              port_clk,      // Oversampling clock of the serial port.
  input  wire logic              scl_i,         // Serial clock pin level.
  output logic                   scl_o,         // Serial clock drive value, always low.
  output logic                   scl_oe,        // Serial clock pull-down while stretching.
  input  wire logic              sda_i,         // Serial data pin level.
  output logic                   sda_o,         // Serial data drive value, always low.
  output logic                   sda_oe,        // Serial data pull-down enable.
  input  wire logic              core_ready,    // Core has finished initialising.
  input  wire logic [15:0]       core_rd_word,  // Core read data for the last read strobe.
  output irt_pkg::irt_cmd_t      core_cmd,      // Register file command strobes.
  output logic                   port_wake      // Keeps the core awake for a transfer.
);

  // Link-domain pin, ready and enable samples, all after two flip-flops.
  logic                scl_s;       // Synchronised serial clock.
  logic                sda_s;       // Synchronised serial data.
  logic                ready_s;     // Synchronised core ready.
  logic                en_l;        // Synchronised clock enable.
  logic                scl_d;       // Previous clock sample for edge detection.
  logic                sda_d;       // Previous data sample for edge detection.

  // Link-domain engine state.
  irt_pkg::irt_state_t state_reg;   // Engine state.
  irt_pkg::irt_state_t nxt_reg;     // State to enter after our acknowledge.
  logic [2:0]          bit_cnt;     // Bit position inside the byte.
  logic [7:0]          shift_reg;   // Byte shifter in both directions.
  logic                ack_on;      // Acknowledge is being driven.
  logic                load_pend;   // Waiting for read data before the first bit.
  logic                stretch_reg; // Holding the serial clock low.
  logic                active_reg;  // A transaction to us is in progress.
  logic [7:0]          ptr_reg;     // Register pointer.
  irt_pkg::irt_lreq_t  lreq_reg;    // Request word held for the core domain.
  logic                req_tgl;     // Request toggle to the core domain.

  // Crossing answers.
  logic                ack_tgl;     // Answer toggle from the core domain.
  logic                ack_s;       // Answer toggle in the link domain.
  logic [7:0]          rsp_byte;    // Read answer, stable while no request pends.
  logic                active_s;    // Transaction level in the core domain.

  // Decoded events.
  logic                start_ev;    // SDA falls while SCL is high.
  logic                stop_ev;     // SDA rises while SCL is high.
  logic                scl_rise;    // Serial clock rising edge.
  logic                scl_fall;    // Serial clock falling edge.
  logic                busy;        // A byte request is still pending.
  logic                rx_done;     // Eighth bit of a received byte sampled.
  logic [7:0]          rx_byte;     // Received byte including the last bit.
  logic                addr_hit;    // Address byte matches and we may answer.
  logic                rd_issue;    // Fetch the next read byte.
  logic                wr_issue;    // Write the received data byte.
  logic                reg_load;    // Received byte is the register address.
  logic                load_next;   // This falling edge leads into a read byte.

  // RULE2 pin sampling
  // Pins are oversampled; the port clock must be many times the 400 kHz bus clock.
  irt_sync #(.W(4), .INIT(irt_pkg::PIN_INIT)) u_pin_sync (
    .clk   (port_clk),
    .rst_n (rst_n),
    .d     ({scl_i, sda_i, core_ready, ce}),
    .q     ({scl_s, sda_s, ready_s, en_l})
  );

  // Answer toggle coming back from the core domain.
  irt_sync #(.W(1), .INIT(1'b0)) u_ack_sync (
    .clk   (port_clk),
    .rst_n (rst_n),
    .d     (ack_tgl),
    .q     (ack_s)
  );

  // Transaction level going to the core domain.
  irt_sync #(.W(1), .INIT(1'b0)) u_act_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (active_reg),
    .q     (active_s)
  );

  // Core-domain end of the byte handshake.
  irt_xfer u_xfer (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .req_tgl  (req_tgl),
    .req      (lreq_reg),
    .rd_word  (core_rd_word),
    .ack_tgl  (ack_tgl),
    .rsp_byte (rsp_byte),
    .cmd      (core_cmd)
  );

  // Edge history of the synchronised pins.
  always_ff @(posedge port_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (en_l) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Bus conditions and byte events.
  always_comb begin
    start_ev  = en_l && scl_s && scl_d && sda_d && !sda_s;
    stop_ev   = en_l && scl_s && scl_d && !sda_d && sda_s;
    scl_rise  = en_l && scl_s && !scl_d;
    scl_fall  = en_l && !scl_s && scl_d;
    busy      = req_tgl != ack_s;
    rx_byte   = {shift_reg[6:0], sda_s};
    rx_done   = scl_rise && (bit_cnt == irt_pkg::BIT_LAST) &&
                (state_reg inside {irt_pkg::ST_ADDR, irt_pkg::ST_REG, irt_pkg::ST_WDATA});
    // RULE1 address match
    // RULE17 ready gate
    addr_hit  = rx_done && (state_reg == irt_pkg::ST_ADDR) &&
                (rx_byte[7:1] == irt_pkg::TARGET_ADDR) && ready_s;
    // RULE6 pointer reads
    rd_issue  = (addr_hit && rx_byte[0]) ||
                (scl_rise && (state_reg == irt_pkg::ST_RACK) && !sda_s);
    wr_issue  = rx_done && (state_reg == irt_pkg::ST_WDATA);
    reg_load  = rx_done && (state_reg == irt_pkg::ST_REG);
    load_next = (state_reg == irt_pkg::ST_RACK) ||
                ((state_reg == irt_pkg::ST_ACK) && ack_on && (nxt_reg == irt_pkg::ST_RDATA));
  end

  // RULE3 register pointer
  // RULE5 kept over STOP
  // The pointer is reset only by rst_n, never by bus conditions.
  always_ff @(posedge port_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_reg  <= irt_pkg::PTR_RESET;
      lreq_reg <= '0;
      req_tgl  <= 1'b0;
    end else if (reg_load) begin
      ptr_reg <= rx_byte;
    end else if (rd_issue || wr_issue) begin
      lreq_reg.wr    <= wr_issue;
      lreq_reg.addr  <= ptr_reg;
      lreq_reg.wdata <= rx_byte;
      req_tgl        <= ~req_tgl;
      // RULE4 auto increment
      ptr_reg        <= ptr_reg + 8'h01;
    end
  end

  // Byte engine: shifting, acknowledge and data drive.
  always_ff @(posedge port_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= irt_pkg::ST_IDLE;
      nxt_reg   <= irt_pkg::ST_IDLE;
      bit_cnt   <= 3'h0;
      shift_reg <= 8'h00;
      ack_on    <= 1'b0;
      load_pend <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (!en_l) begin
      state_reg <= state_reg;
    end else if (start_ev) begin
      // A START or repeated START always restarts address reception.
      state_reg <= irt_pkg::ST_ADDR;
      bit_cnt   <= 3'h0;
      ack_on    <= 1'b0;
      load_pend <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= irt_pkg::ST_IDLE;
      ack_on    <= 1'b0;
      load_pend <= 1'b0;
      sda_oe    <= 1'b0;
    end else if (load_pend) begin
      // The clock is stretched, so the first bit can wait for the core.
      if (!busy) begin
        shift_reg <= rsp_byte;
        sda_oe    <= ~rsp_byte[7];
        bit_cnt   <= 3'h0;
        load_pend <= 1'b0;
      end
    end else begin
      unique case (state_reg)
        irt_pkg::ST_IDLE: begin
          bit_cnt <= 3'h0;
        end
        irt_pkg::ST_ADDR, irt_pkg::ST_REG, irt_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_reg <= rx_byte;
            bit_cnt   <= bit_cnt + 3'h1;
            if (rx_done && (state_reg == irt_pkg::ST_ADDR) && !addr_hit) begin
              // Another target is addressed or the core is not ready; stay off the bus until START.
              state_reg <= irt_pkg::ST_IDLE;
            end else if (rx_done) begin
              state_reg <= irt_pkg::ST_ACK;
              if (state_reg != irt_pkg::ST_ADDR) begin
                nxt_reg <= irt_pkg::ST_WDATA;
              end else if (rx_byte[0]) begin
                nxt_reg <= irt_pkg::ST_RDATA;
              end else begin
                nxt_reg <= irt_pkg::ST_REG;
              end
            end
          end
        end
        irt_pkg::ST_ACK: begin
          // RULE11 ninth clock acknowledge
          if (scl_fall && !ack_on) begin
            ack_on <= 1'b1;
            sda_oe <= 1'b1;
          end else if (scl_fall) begin
            ack_on    <= 1'b0;
            sda_oe    <= 1'b0;
            bit_cnt   <= 3'h0;
            state_reg <= nxt_reg;
            load_pend <= nxt_reg == irt_pkg::ST_RDATA;
          end
        end
        irt_pkg::ST_RDATA: begin
          // Data change only while the clock is low.
          if (scl_fall && (bit_cnt == irt_pkg::BIT_LAST)) begin
            sda_oe    <= 1'b0;
            state_reg <= irt_pkg::ST_RACK;
          end else if (scl_fall) begin
            bit_cnt   <= bit_cnt + 3'h1;
            shift_reg <= {shift_reg[6:0], 1'b0};
            sda_oe    <= ~shift_reg[6];
          end
        end
        irt_pkg::ST_RACK: begin
          // RULE15 release on not-acknowledge
          if (scl_rise && sda_s) begin
            state_reg <= irt_pkg::ST_IDLE;
          end else if (scl_fall) begin
            state_reg <= irt_pkg::ST_RDATA;
            load_pend <= 1'b1;
          end
        end
      endcase
    end
  end

  // Clock stretching holds SCL low until the core has served the pending byte.
  // This trades bus throughput for freedom from any timing link between the clocks.
  always_ff @(posedge port_clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_reg <= 1'b0;
    end else if (!en_l) begin
      stretch_reg <= stretch_reg;
    end else if (start_ev || stop_ev) begin
      stretch_reg <= 1'b0;
    end else if (scl_fall && (state_reg != irt_pkg::ST_IDLE) && (busy || load_next)) begin
      stretch_reg <= 1'b1;
    end else if (!busy && !load_pend) begin
      stretch_reg <= 1'b0;
    end
  end

  // RULE18 wake request
  // The level is high from the address match until the engine returns to ST_IDLE or ST_ADDR.
  // Rising on the match itself, the level reaches the core in the same cycle as the first read strobe.
  always_ff @(posedge port_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_reg <= 1'b0;
    end else if (en_l) begin
      active_reg <= addr_hit ||
                    ((state_reg != irt_pkg::ST_IDLE) && (state_reg != irt_pkg::ST_ADDR));
    end
  end

  // Core-domain copy of the wake level.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_wake <= 1'b0;
    end else if (ce) begin
      port_wake <= active_s;
    end
  end

  // Open-drain drive values are always low; only the enables move.
  always_ff @(posedge port_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign scl_oe = stretch_reg;

endmodule

// file: verif/irt_target_monitor.sv
// Assertions on the target's command strobes and pin drives.
// Assumes it is bound to irt_target and sees only that module's ports.
module irt_target_monitor (
  input wire logic              sys_clk,      // Core clock.
  input wire logic              rst_n,        // Reset, active low.
  input wire logic              ce,           // Clock enable.
  input wire logic              port_clk,     // Port clock.
  input wire logic              scl_i,        // Clock pin.
  input wire logic              scl_o,        // Clock drive.
  input wire logic              scl_oe,       // Clock stretch.
  input wire logic              sda_i,        // Data pin.
  input wire logic              sda_o,        // Data drive.
  input wire logic              sda_oe,       // Data pull-down.
  input wire logic              core_ready,   // Core ready.
  input wire logic [15:0]       core_rd_word, // Read word.
  input wire irt_pkg::irt_cmd_t core_cmd,     // Command.
  input wire logic              port_wake     // Wake level.
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  one_cmd_a: assert property (!(core_cmd.rd && core_cmd.wr))
    else $error("read and write strobes together");
  // Strobes are single pulses with the byte handshake between them.
  cmd_gap_a: assert property ((core_cmd.rd || core_cmd.wr) |=>
    !(core_cmd.rd || core_cmd.wr) [*4]) else $error("strobes too close");
  pair_wr_a: assert property (core_cmd.pair |->
    core_cmd.wr && core_cmd.addr == 8'h73) else $error("pair off its write");
  pair_word_a: assert property (core_cmd.pair |->
    core_cmd.wword[15:8] == core_cmd.wdata) else $error("pair word wrong");
  // A core that is still starting must never see the port wake.
  no_wake_a: assert property (!core_ready [*3] |-> !port_wake)
    else $error("woke while core not ready");
  cmd_wake_a: assert property ((core_cmd.rd || core_cmd.wr) |-> port_wake)
    else $error("strobe without wake");
  drive_low_a: assert property (!(sda_o || scl_o))
    else $error("pin drive value high");
  reset_quiet_a: assert property ($rose(rst_n) |->
    !(sda_oe || scl_oe || port_wake)) else $error("busy after reset");
  cover property (core_cmd.pair);
  cover property (core_cmd.rd);
  cover property (scl_oe);
endmodule

bind irt_target irt_target_monitor irt_target_monitor_i (.sys_clk, .rst_n, .ce,
  .port_clk, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .core_ready,
  .core_rd_word, .core_cmd, .port_wake);

// file: verif/irt_ctrl_model.sv
// Behavioural two-wire bus controller driving the target's pins.
// Assumes open-drain lines whose pull-ups are resolved in the bench.
module irt_ctrl_model (
  input wire logic clk,    // Bench timing clock.
  input wire logic scl,    // Resolved clock line.
  input wire logic sda,    // Resolved data line.
  output logic     scl_dn, // Pulls the clock line low.
  output logic     sda_dn  // Pulls the data line low.
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_dn = 1'b0;
    sda_dn = 1'b0;
  end
  task automatic hp();
    repeat (13) @(posedge clk);
  endtask
  // Waiting on the released clock honours stretching by the target.
  task automatic bit_io(input logic b, output logic r);
    @(posedge clk);
    sda_dn <= !b;
    hp();
    scl_dn <= 1'b0;
    @(posedge clk);
    while (!scl) @(posedge clk);
    hp();
    r = sda;
    scl_dn <= 1'b1;
  endtask
  task automatic start();
    sda_dn <= 1'b0;
    hp();
    scl_dn <= 1'b0;
    hp();
    sda_dn <= 1'b1;
    hp();
    scl_dn <= 1'b1;
  endtask
  task automatic stop();
    @(posedge clk);
    sda_dn <= 1'b1;
    hp();
    scl_dn <= 1'b0;
    hp();
    sda_dn <= 1'b0;
    hp();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule

// file: verif/irt_target_tb.sv
// Self-checking bench for the two-wire register target and a core register model.
// Assumes the controller model and the bound checker are compiled alongside.
module irt_target_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic              sys_clk = 1'b0;         // Core clock.
  logic              port_clk = 1'b0;        // Port clock.
  logic              rst_n, ce, core_ready;  // Design controls.
  logic [15:0]       core_rd_word = 16'h0000; // Core read word.
  irt_pkg::irt_cmd_t core_cmd;               // Core command.
  logic              scl_o, scl_oe, sda_o;   // Clock pin outputs and data drive.
  logic              sda_oe, port_wake;      // Other outputs.
  logic              scl_dn, sda_dn;         // Controller pulls.
  logic [7:0]        mem [256];              // Core registers.
  int                fail_count = 0;         // Mismatches.
  int                n_tests = 0;            // Comparisons.
  wire               scl = !(scl_oe || scl_dn); // Pulled-up clock line.
  wire               sda = !(sda_oe || sda_dn); // Pulled-up data line.
  always #50 sys_clk = ~sys_clk;
  always #24 port_clk = ~port_clk;
  // Core model; lone writes to the wide field are dropped, only pairs land.
  always @(posedge sys_clk) begin
    if (core_cmd.rd) core_rd_word <= {mem[core_cmd.addr + 8'h01], mem[core_cmd.addr]};
    if (core_cmd.wr && core_cmd.pair) begin
      mem[core_cmd.addr - 8'h01] <= core_cmd.wword[7:0];
      mem[core_cmd.addr] <= core_cmd.wword[15:8];
    end else if (core_cmd.wr && core_cmd.addr[7:1] != 7'h39) begin
      mem[core_cmd.addr] <= core_cmd.wdata;
    end
  end
  irt_target irt_target_i (.sys_clk, .rst_n, .ce, .port_clk, .scl_i(scl), .scl_o,
    .scl_oe, .sda_i(sda), .sda_o, .sda_oe, .core_ready, .core_rd_word, .core_cmd,
    .port_wake);
  irt_ctrl_model irt_ctrl_model_i (.clk(sys_clk), .scl, .sda, .scl_dn, .sda_dn);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sel(input logic [7:0] b, input logic exp_ack);
    logic a;
    irt_ctrl_model_i.wbyte(b, a);
    check({7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic w_bytes(input logic [7:0] rg, input logic [7:0] d [$]);
    irt_ctrl_model_i.start();
    sel(8'hc8, 1'b1);
    sel(rg, 1'b1);
    check({7'h00, port_wake}, 8'h01);
    foreach (d[i]) sel(d[i], 1'b1);
    irt_ctrl_model_i.stop();
  endtask
  // With skip set the read carries on from the kept pointer.
  task automatic r_bytes(input logic skip, input logic [7:0] rg, input logic [7:0] e [$]);
    logic [7:0] d;
    if (!skip) begin
      irt_ctrl_model_i.start();
      sel(8'hc8, 1'b1);
      sel(rg, 1'b1);
    end
    irt_ctrl_model_i.start();
    sel(8'hc9, 1'b1);
    foreach (e[i]) begin
      irt_ctrl_model_i.rbyte(i < e.size() - 1, d);
      check(d, e[i]);
    end
    irt_ctrl_model_i.hp();
    check({7'h00, sda_oe}, 8'h00);
    irt_ctrl_model_i.stop();
  endtask
  task automatic t_burst();
    w_bytes(8'h10, '{8'ha5, 8'h5a});
    r_bytes(1'b0, 8'h10, '{8'ha5, 8'h5a});
    r_bytes(1'b1, 8'h00, '{8'h2e});
  endtask
  // A lone high-byte write must not disturb the paired value.
  task automatic t_wide();
    w_bytes(8'h72, '{8'h34, 8'h12});
    w_bytes(8'h73, '{8'hff});
    r_bytes(1'b0, 8'h72, '{8'h34, 8'h12});
  endtask
  task automatic t_refuse();
    irt_ctrl_model_i.start();
    sel(8'hca, 1'b0);
    irt_ctrl_model_i.stop();
    core_ready <= 1'b0;
    irt_ctrl_model_i.start();
    sel(8'hc8, 1'b0);
    irt_ctrl_model_i.stop();
    core_ready <= 1'b1;
    r_bytes(1'b1, 8'h00, '{8'h48});
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h3c;
    rst_n = 1'b0;
    ce = 1'b0;
    core_ready = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    ce <= 1'b1;
    core_ready <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_burst();
    t_wide();
    t_refuse();
    end_of_test();
  end
  // Whole run needs about 0.8 ms; this cuts a hang short.
  initial begin
    #4000000;
    fail_count++;
    end_of_test();
  end
endmodule
